/* File: hw/uer_pkg.sv */
package uer_pkg;
  // Register byte offsets
  localparam logic [7:0] UER_CTRL_OFS = 8'h00;
  localparam logic [7:0] UER_STAT_OFS = 8'h04;
  localparam logic [7:0] UER_CNT_OFS = 8'h08;
  localparam logic [7:0] UER_ID_OFS = 8'h0c;
  // Control field positions
  localparam int UER_CTRL_NF_EN = 0;
  localparam int UER_CTRL_COR_EN = 1;
  localparam int UER_CTRL_LEGACY = 2;
  localparam int UER_CTRL_W = 3;
  localparam logic [2:0] UER_CTRL_RST = 3'h3;
  // Status field positions (sticky, write one to clear)
  localparam int UER_ST_UR = 0;
  localparam int UER_ST_CA = 1;
  localparam int UER_ST_TO = 2;
  localparam int UER_ST_ECRC = 3;
  localparam int UER_ST_COR = 4;
  localparam int UER_ST_UC = 5;
  localparam int UER_ST_ADVISORY_NONFATAL = 6;
  localparam int UER_ST_W = 7;
  localparam logic [15:0] UER_ID_RST = 16'h0000;
  localparam int UER_DEPTH = 4;
  localparam logic [1:0] UER_D0 = 2'h0;
  // Completion status codes
  localparam logic [2:0] UER_CPL_UR = 3'h1;
  localparam logic [2:0] UER_CPL_CA = 3'h4;

  typedef enum logic [2:0] {
    UER_MSG_NONE, UER_MSG_NONFATAL, UER_MSG_COR
  } uer_msg_t;

  typedef struct packed {
    logic unsupported_n;
    logic abort_n;
    logic timeout_n;
    logic ecrc_n;
    logic correctable_n;
    logic unexpected_n;
    logic posted_error_select_n;
    logic locked_request_flag_n;
    logic [47:0] failed_request_header;
  } uer_report_t;

  typedef struct packed {
    logic valid;
    logic locked;
    logic [2:0] status;
    logic [47:0] header;
  } uer_cpl_t;

  typedef struct packed {
    logic valid;
    logic [15:0] requester_id;
  } uer_inb_t;
endpackage

/* File: hw/uer_core.sv */
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
// How it works
// RULE1 - Application reports at most one error per clock cycle.
// RULE2 - Several errors in one packet: application reports just one, its choice.
// RULE3 - Application reports only while power state equals D0.
// RULE4 - Non-D0 with wake enabled: application may pulse wake, then waits for D0.
// RULE5 - Non-D0 without wake enable: application simply waits for D0.
// RULE6 - Unsupported request: posted sends non-fatal message, non-posted UR completion.
// RULE7 - Completer abort: non-posted sends abort completion, posted non-fatal message.
// RULE8 - Correctable report sends correctable message if enabled, qualifier ignored.
// RULE9 - Unexpected completion report is advisory non-fatal; nothing sent.
// RULE10 - Non-posted error: qualifier high, header given with the strobe.
// RULE11 - Application reports only valid type and qualifier combinations.
// RULE12 - Full completion buffer deasserts ready; application stops UR and abort.
// RULE13 - Status bits always set for every report, messages enabled or not.
// RULE14 - Application times requests; timeout strobe sends an error message.
// RULE15 - Application treats completions after timeout as unexpected.
// RULE16 - Device drops completions with foreign requester id as advisory errors.
// RULE17 - Legacy mode locked flag makes the completion a locked completion.
// RULE18 - Application reports unsupported request for unknown requests, qualifier by type.
// RULE19 - Unused address on non-posted request: application reports completer abort.
// RULE20 - Application reports abort when it cannot complete a non-posted request.
// RULE21 - Device never checks end-to-end CRC; application report gives non-fatal message.
// RULE22 - Strobes active low, sampled on rising edge, one cycle per error.
module uer_core import uer_pkg::*; #(
  parameter int DEPTH = UER_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Error report from the application
  input wire uer_report_t report,
  output logic error_completion_ready_n,
  // Power state seen by the application
  input wire logic [1:0] device_power_state,
  // Inbound completions seen by the core
  input wire uer_inb_t inbound_cpl,
  output logic inbound_pass,
  // Transmit side
  output uer_msg_t msg_out,
  input wire logic cpl_take,
  output uer_cpl_t cpl_out
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [UER_CTRL_W-1:0] ctrl;
    logic [UER_ST_W-1:0] status;
    logic [15:0] own_id;
    logic [15:0] drop_cnt;
    logic [AW:0] count;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic rdy_n;
    uer_msg_t msg;
    uer_cpl_t cpl;
    logic pass;
  } uer_state_t;

  uer_state_t st_ff;
  uer_state_t nxt_st;
  uer_cpl_t fifo_ff [DEPTH];
  logic push;
  uer_cpl_t push_data;

  function automatic logic strobe(input logic s_n);
    return ~s_n;
  endfunction

  always_comb begin
    logic acc;
    logic pop;
    logic [UER_ST_W-1:0] setb;
    logic [UER_ST_W-1:0] clrb;
    logic np;
    acc = 1'b0;
    pop = 1'b0;
    setb = '0;
    clrb = '0;
    np = ~report.posted_error_select_n;
    np = ~np;
    nxt_st = st_ff;
    push = 1'b0;
    push_data = '0;
    nxt_st.msg = UER_MSG_NONE;
    nxt_st.pass = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    // Reports are accepted only in D0; the application is meant to hold off otherwise
    if (device_power_state == UER_D0) begin // [RULE3]
      if (strobe(report.unsupported_n)) begin // [RULE22]
        setb[UER_ST_UR] = 1'b1; // [RULE13]
        if (np) begin // [RULE6]
          push = 1'b1;
          push_data.status = UER_CPL_UR;
        end else if (st_ff.ctrl[UER_CTRL_NF_EN]) begin
          nxt_st.msg = UER_MSG_NONFATAL;
        end
      end else if (strobe(report.abort_n)) begin
        setb[UER_ST_CA] = 1'b1; // [RULE13]
        if (np) begin // [RULE7]
          push = 1'b1;
          push_data.status = UER_CPL_CA;
        end else if (st_ff.ctrl[UER_CTRL_NF_EN]) begin
          nxt_st.msg = UER_MSG_NONFATAL;
        end
      end else if (strobe(report.timeout_n) || strobe(report.ecrc_n)) begin
        setb[UER_ST_TO] = strobe(report.timeout_n);
        setb[UER_ST_ECRC] = strobe(report.ecrc_n); // [RULE21]
        if (st_ff.ctrl[UER_CTRL_NF_EN]) nxt_st.msg = UER_MSG_NONFATAL;
      end else if (strobe(report.correctable_n)) begin
        setb[UER_ST_COR] = 1'b1;
        if (st_ff.ctrl[UER_CTRL_COR_EN]) nxt_st.msg = UER_MSG_COR; // [RULE8]
      end else if (strobe(report.unexpected_n)) begin
        setb[UER_ST_UC] = 1'b1; // [RULE9]
        setb[UER_ST_ADVISORY_NONFATAL] = 1'b1;
      end
    end
    if (push) begin
      push_data.valid = 1'b1;
      push_data.header = report.failed_request_header; // [RULE10]
      push_data.locked = st_ff.ctrl[UER_CTRL_LEGACY] &
                         ~report.locked_request_flag_n; // [RULE17]
      // A push with the buffer full is dropped; the application broke the back-pressure
      if (st_ff.count == (AW+1)'(DEPTH)) push = 1'b0;
    end
    // Foreign completions never reach the application
    if (inbound_cpl.valid) begin
      if (inbound_cpl.requester_id != st_ff.own_id) begin // [RULE16]
        setb[UER_ST_UC] = 1'b1;
        setb[UER_ST_ADVISORY_NONFATAL] = 1'b1;
        nxt_st.drop_cnt = st_ff.drop_cnt + 16'h0001;
      end else begin
        nxt_st.pass = 1'b1;
      end
    end
    // Completion output register
    if (st_ff.cpl.valid && cpl_take) nxt_st.cpl.valid = 1'b0;
    if ((!nxt_st.cpl.valid) && st_ff.count != '0) begin
      nxt_st.cpl = fifo_ff[st_ff.rd_ptr];
      pop = 1'b1;
      nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
    end
    if (push) nxt_st.wr_ptr = st_ff.wr_ptr + AW'(1);
    nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    // Ready falls as soon as the last slot is taken
    nxt_st.rdy_n = (nxt_st.count == (AW+1)'(DEPTH)); // [RULE12]
    // APB answer comes one cycle after the access phase is taken
    if (psel && penable && !st_ff.pready) begin
      acc = 1'b1;
      nxt_st.pready = 1'b1;
      unique case (paddr)
        UER_CTRL_OFS: nxt_st.prdata = 32'(st_ff.ctrl);
        UER_STAT_OFS: nxt_st.prdata = 32'(st_ff.status);
        UER_CNT_OFS: nxt_st.prdata = {16'h0000, st_ff.drop_cnt};
        UER_ID_OFS: nxt_st.prdata = 32'(st_ff.own_id);
        default: begin
          nxt_st.prdata = '0;
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
    // Writes land on the edge where the master sees pready, never a cycle early
    if (psel && penable && st_ff.pready && pwrite) begin
      unique case (paddr)
        UER_CTRL_OFS: nxt_st.ctrl = pwdata[UER_CTRL_W-1:0];
        UER_STAT_OFS: clrb = pwdata[UER_ST_W-1:0];
        UER_CNT_OFS: nxt_st.drop_cnt = 16'h0000;
        UER_ID_OFS: nxt_st.own_id = pwdata[15:0];
        default: ;
      endcase
    end
    if (!acc) nxt_st.prdata = st_ff.prdata;
    // Set wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~clrb) | setb;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0, ctrl: UER_CTRL_RST,
                 status: '0, own_id: UER_ID_RST, drop_cnt: 16'h0, count: '0,
                 rd_ptr: '0, wr_ptr: '0, rdy_n: 1'b0, msg: UER_MSG_NONE,
                 cpl: '0, pass: 1'b0};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && push) fifo_ff[st_ff.wr_ptr] <= push_data;
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign error_completion_ready_n = st_ff.rdy_n;
  assign inbound_pass = st_ff.pass;
  assign msg_out = st_ff.msg;
  assign cpl_out = st_ff.cpl;

endmodule // uer_core

/* File: verif/uer_chk_props.sv */
`timescale 1ns/1ns
module uer_chk import uer_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Report path
  input wire uer_report_t report,
  input wire logic [1:0] device_power_state,
  input wire logic error_completion_ready_n,
  input wire uer_msg_t msg_out,
  input wire logic cpl_take,
  input wire uer_cpl_t cpl_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire go = clk_en && device_power_state == UER_D0;
  wire np = go && report.posted_error_select_n;
  property p_ur; np && !report.unsupported_n |=> msg_out == UER_MSG_NONE; endproperty
  a_ur: assert property (p_ur) else $error("np ur sent msg");
  property p_ca; np && !report.abort_n |=> msg_out == UER_MSG_NONE; endproperty
  a_ca: assert property (p_ca) else $error("np ca sent msg");
  property p_cor; go && !report.correctable_n |=> msg_out != UER_MSG_NONFATAL; endproperty
  a_cor: assert property (p_cor) else $error("cor gave nonfatal");
  property p_uc; go && !report.unexpected_n |=> msg_out == UER_MSG_NONE; endproperty
  a_uc: assert property (p_uc) else $error("unexpected sent msg");
  property p_ecrc; go && !report.ecrc_n |=> msg_out != UER_MSG_COR; endproperty
  a_ecrc: assert property (p_ecrc) else $error("ecrc gave cor");
  property p_hold; cpl_out.valid && !cpl_take |=> $stable(cpl_out); endproperty
  a_hold: assert property (p_hold) else $error("cpl changed untaken");
  property p_full; error_completion_ready_n |-> cpl_out.valid; endproperty
  a_full: assert property (p_full) else $error("full with no cpl");
  property p_one; msg_out != UER_MSG_NONE |-> $past(report[55:50]) != 6'h3f; endproperty
  a_one: assert property (p_one) else $error("msg without strobe");
  c_full: cover property (error_completion_ready_n);
  c_cpl: cover property (cpl_out.valid && cpl_take);
  c_cor: cover property (msg_out == UER_MSG_COR);
endmodule // uer_chk
bind uer_core uer_chk chk_u (.clk, .resetn, .clk_en, .report, .device_power_state,
  .error_completion_ready_n, .msg_out, .cpl_take, .cpl_out);

/* File: verif/uer_app.sv */
`timescale 1ns/1ns
module uer_app import uer_pkg::*; (
  // Clock and bench request
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic posted_n,
  input wire logic locked_n,
  input wire logic [47:0] hdr,
  // Core side
  input wire logic [1:0] device_power_state,
  input wire logic error_completion_ready_n,
  output uer_report_t report
);
  logic held = 1'b0;
  // Holds off non-posted UR and abort while the core cannot buffer completions
  wire full = error_completion_ready_n && posted_n && kind < 3'h2;
  // A report that meets a sleeping device or a full buffer waits; it is never lost
  wire ok = (go || held) && device_power_state == UER_D0 && !full;
  initial report = '1;
  // One strobe a cycle; an idle header is scrambled so stale data is never seen
  always @(posedge clk) begin
    if (ok) report <= {~(6'h20 >> kind), posted_n, locked_n, hdr};
    else report <= {8'hff, ~hdr};
    held <= !ok && (go || held);
  end
endmodule // uer_app

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb import uer_pkg::*; ();
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, cpl_take = 0, go = 0;
  logic posted_n = 1, locked_n = 1, pready, pslverr, ready_n, pass, err;
  logic [2:0] kind = 0;
  logic [1:0] pstate = 2'h0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [47:0] hdr = 0, h = 48'h0abc_1234_5670;
  uer_report_t report;
  uer_inb_t inb = '0;
  uer_msg_t msg, seen;
  uer_cpl_t cpl;
  int failures = 0, n_compared = 0, cycles = 0, n;
  initial forever #5 clk = ~clk;
  uer_core dut_u (.clk, .resetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .report, .error_completion_ready_n(ready_n),
    .device_power_state(pstate), .inbound_cpl(inb), .inbound_pass(pass), .msg_out(msg),
    .cpl_take, .cpl_out(cpl));
  uer_app app_u (.clk, .go, .kind, .posted_n, .locked_n, .hdr, .device_power_state(pstate),
    .error_completion_ready_n(ready_n), .report);
  task automatic report_and_stop;
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic send(input logic [2:0] k, input logic p, input logic l);
    @(posedge clk);
    go <= 1;
    kind <= k;
    posted_n <= p;
    locked_n <= l;
    hdr <= h + k;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    #1 seen = msg;
  endtask
  task automatic stat(input logic [2:0] k);
    apb(0, UER_STAT_OFS, 0);
    chk("status", rd[k], 1);
    apb(1, UER_STAT_OFS, 32'h7f);
  endtask
  task automatic getcpl(input logic [2:0] st, input logic lk, input logic [2:0] k);
    n = 0;
    do @(posedge clk); while (cpl.valid !== 1 && ++n < 8);
    chk("cpl", {cpl.valid, cpl.locked, cpl.status, cpl.header}, {1'b1, lk, st, h + k});
    cpl_take <= 1;
    @(posedge clk);
    cpl_take <= 0;
  endtask
  task automatic inbound(input logic [15:0] id, input logic e);
    @(posedge clk);
    inb <= '{1'b1, id};
    @(posedge clk);
    inb <= '0;
    #1 chk("pass", pass, e);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    apb(0, UER_CTRL_OFS, 0);
    chk("ctrl", rd, 3);
    apb(0, 8'h10, 0);
    chk("slverr", err, 1);
    pstate <= 2'h3;
    send(2, 0, 1);
    chk("asleep msg", seen, UER_MSG_NONE);
    pstate <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk("woken msg", msg, UER_MSG_NONFATAL);
    for (int k = 0; k < 6; k++) begin
      send(3'(k), 0, 1);
      chk("msg", seen, k == 4 ? UER_MSG_COR : k == 5 ? UER_MSG_NONE : UER_MSG_NONFATAL);
      stat(3'(k));
    end
    for (int k = 0; k < 2; k++) begin
      send(3'(k), 1, 1);
      chk("np msg", seen, UER_MSG_NONE);
      getcpl(k ? UER_CPL_CA : UER_CPL_UR, 0, 3'(k));
      apb(1, UER_CTRL_OFS, 7);
      send(3'(k), 1, 0);
      getcpl(k ? UER_CPL_CA : UER_CPL_UR, 1, 3'(k));
      apb(1, UER_CTRL_OFS, 0);
    end
    for (int k = 2; k < 5; k++) begin
      send(3'(k), 0, 1);
      chk("off msg", seen, UER_MSG_NONE);
      stat(3'(k));
    end
    repeat (UER_DEPTH + 2) send(0, 1, 1);
    chk("ready_n", ready_n, 1);
    repeat (UER_DEPTH + 2) getcpl(UER_CPL_UR, 0, 0);
    repeat (3) @(posedge clk);
    chk("drained", {cpl.valid, ready_n}, 0);
    apb(1, UER_ID_OFS, 32'h42);
    inbound(16'h42, 1);
    inbound(16'h43, 0);
    apb(0, UER_CNT_OFS, 0);
    chk("drops", rd, 1);
    apb(0, UER_STAT_OFS, 0);
    chk("advisory_nonfatal", rd, 32'h61);
    report_and_stop;
  end
endmodule // tb
